/* core/spe_entry.sv */
// entry and mode control for the two-wire serial programming port
// assumes pins arrive asynchronous to clk_i; the high programming voltage
// is reported by an analog detector as a plain level on hv_detect_i
`timescale 1ns/1ps
`include "spe_defs.svh"

// Overview of operation
// - the data pin is two-way and the serial clock is an input driven by the programmer.
// - program, id and configuration writes are granted only in program/verify mode.
// - low-voltage entry is possible only while the low-voltage enable bit is one.
// - a low-voltage session lasts only while master clear stays low.
// - with low-voltage enable set, master clear always acts as a reset input.
// - clearing the low-voltage enable bit is allowed only in a high-voltage session.
module spe_entry
    import spe_pkg::*;
#(
    parameter int          KEY_BITS  = `SPE_KEY_BITS,
    parameter logic [31:0] KEY_VALUE = `SPE_KEY_VALUE
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // programming pins
    input  wire logic prog_serial_clock_i,
    input  wire logic prog_serial_data_i,
    input  wire logic master_clear_n_i,
    input  wire logic hv_detect_i,
    // data pin drive from the command engine
    input  wire logic cmd_data_out_i,
    input  wire logic cmd_data_oe_i,
    output logic      prog_serial_data_o,
    output logic      prog_serial_data_oe_o,
    // configuration
    input  wire logic low_voltage_entry_enable_i,
    input  wire logic en_clear_req_i,
    // status to the core
    output logic      prog_mode_o,
    output logic      hv_session_o,
    output logic      reset_fn_en_o,
    output logic      nvm_write_en_o,
    output logic      en_clear_grant_o
);

    // elaboration check: the shifter and the bit counter serve a 32-bit key only
    if (KEY_BITS != 32) begin : g_bad_key_bits
        $error("KEY_BITS must be 32");
    end

    // two-stage synchronisers for every pin
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= 5'h1f;
            sync_r <= 5'h1f;
        end else begin
            meta_r <= {prog_serial_clock_i, prog_serial_data_i, master_clear_n_i,
                       hv_detect_i, low_voltage_entry_enable_i};
            sync_r <= meta_r;
        end
    end
    wire sclk_s = sync_r[4];
    wire sdat_s = sync_r[3];
    wire mc_s   = sync_r[2];
    wire hv_s   = sync_r[1];
    wire lve_s  = sync_r[0];

    // rising edge of the serial clock, seen after the synchroniser
    logic sclk_d_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // same level as the synchroniser's reset, so no false edge follows reset
            sclk_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end
    wire sclk_rise = sclk_s & ~sclk_d_r;

    // high voltage with clock and data low opens an hv session
    wire hv_entry = hv_s & ~sclk_s & ~sdat_s;

    spe_state_type state_r;
    spe_state_type state_nxt;
    logic [31:0]   key_r;
    logic [5:0]    cnt_r;
    logic          hv_r;

    // entry sequencer; hv wins over any low-voltage shifting
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SPE_IDLE: begin
                if (hv_entry) begin
                    state_nxt = SPE_PROG;
                end else if (!mc_s && lve_s) begin
                    state_nxt = SPE_SHIFT;
                end
            end
            SPE_SHIFT: begin
                if (hv_entry) begin
                    state_nxt = SPE_PROG;
                end else if (mc_s || !lve_s) begin
                    state_nxt = SPE_IDLE;
                end else if (cnt_r == 6'h20) begin
                    // full key: enter only on an exact match
                    state_nxt = (key_r == KEY_VALUE) ? SPE_PROG : SPE_IDLE;
                end
            end
            SPE_PROG: begin
                if (hv_r ? !hv_s : mc_s) begin
                    state_nxt = SPE_IDLE;
                end
            end
            default: state_nxt = SPE_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= SPE_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // key shifter, msb first; a mismatch falls back to idle and the count restarts
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_r <= 32'h0;
            cnt_r <= 6'h0;
        end else if (state_r != SPE_SHIFT) begin
            key_r <= 32'h0;
            cnt_r <= 6'h0;
        end else if (sclk_rise && cnt_r != 6'h20) begin
            key_r <= {key_r[30:0], sdat_s};
            cnt_r <= cnt_r + 6'h1;
        end
    end

    // session kind is latched on entry
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hv_r <= 1'b0;
        end else if (state_r != SPE_PROG && state_nxt == SPE_PROG) begin
            hv_r <= hv_entry;
        end else if (state_nxt != SPE_PROG) begin
            hv_r <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prog_mode_o           <= 1'b0;
            hv_session_o          <= 1'b0;
            reset_fn_en_o         <= 1'b1;
            nvm_write_en_o        <= 1'b0;
            en_clear_grant_o      <= 1'b0;
            prog_serial_data_o    <= 1'b0;
            prog_serial_data_oe_o <= 1'b0;
        end else begin
            prog_mode_o           <= state_r == SPE_PROG;
            hv_session_o          <= state_r == SPE_PROG && hv_r;
            reset_fn_en_o         <= lve_s;
            nvm_write_en_o        <= state_r == SPE_PROG;
            en_clear_grant_o      <= en_clear_req_i && state_r == SPE_PROG && hv_r;
            // data pin driven only inside a session
            prog_serial_data_o    <= cmd_data_out_i;
            prog_serial_data_oe_o <= cmd_data_oe_i && state_r == SPE_PROG;
        end
    end

    // assertions
    a_lv_needs_enable: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == SPE_SHIFT) |-> $past(lve_s))
        else $error("shifting without low-voltage enable");

    a_enable_clear_hv: assert property (@(posedge clk_i) disable iff (!resetn_i)
        en_clear_grant_o |-> $past(hv_r) && $past(state_r == SPE_PROG))
        else $error("enable clear granted outside hv session");

    a_reset_forced: assert property (@(posedge clk_i) disable iff (!resetn_i)
        lve_s |=> reset_fn_en_o)
        else $error("reset function off while enabled");

    a_lv_session_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == SPE_PROG && !hv_r && mc_s) |=> state_r == SPE_IDLE)
        else $error("lv session outlived master clear");

    a_key_match: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == SPE_SHIFT && cnt_r == 6'h20 && key_r != KEY_VALUE && !hv_entry)
        |=> state_r == SPE_IDLE)
        else $error("entry on wrong key");

    a_write_in_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
        nvm_write_en_o |-> $past(state_r) == SPE_PROG)
        else $error("write enabled outside program mode");

    a_shift_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_r == SPE_SHIFT && sclk_rise && cnt_r < 6'h20 && state_nxt == SPE_SHIFT)
        |=> cnt_r == $past(cnt_r) + 6'h1)
        else $error("key bit not counted");

    a_data_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        prog_serial_data_oe_o |-> $past(state_r) == SPE_PROG)
        else $error("data pin driven outside session");

    // entry steps: request seen, state taken next edge, outputs shown one edge later
    sequence s_hv_request;
        state_r == SPE_IDLE && hv_entry;
    endsequence

    sequence s_key_accepted;
        state_r == SPE_SHIFT && cnt_r == 6'h20 && key_r == KEY_VALUE
            && !hv_entry && !mc_s && lve_s;
    endsequence

    sequence s_prog_shown;
        prog_mode_o && nvm_write_en_o;
    endsequence

    a_hv_entry: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_hv_request |=> (state_r == SPE_PROG && hv_r) ##1 s_prog_shown ##0 hv_session_o)
        else $error("high-voltage entry not taken");

    a_key_accept: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_key_accepted |=> (state_r == SPE_PROG && !hv_r) ##1 s_prog_shown)
        else $error("matching key did not open a session");

endmodule

/* core/spe_defs.svh */
// constants for the serial programming entry block
// assumes inclusion by the package, the design module and the bench
`ifndef SPE_DEFS_SVH
`define SPE_DEFS_SVH

`define SPE_KEY_BITS      32
// arbitrary key value of our own making; set the real one through the parameter
`define SPE_KEY_VALUE     32'h5ac3e10f
`define SPE_STATE_W       2

`endif

/* core/spe_pkg.sv */
// types for the serial programming entry block
// assumes spe_defs.svh is on the include path
`include "spe_defs.svh"
package spe_pkg;
    typedef enum logic [`SPE_STATE_W-1:0] {
        SPE_IDLE  = 2'b00,
        SPE_SHIFT = 2'b01,
        SPE_PROG  = 2'b10
    } spe_state_type;

    typedef enum logic {
        SPE_ENTRY_LV = 1'b0,
        SPE_ENTRY_HV = 1'b1
    } spe_entry_type;
endpackage

/* verification/spe_prog_model.sv */
// programmer model: drives serial clock, data, master clear and high voltage
// assumes the bench resolves the data pin from both parties' enables
`timescale 1ns/1ps
module spe_prog_model (
    // pins driven toward the device
    output logic sclk_o,
    output logic sdat_o,
    output logic sdat_oe_o,
    output logic mc_n_o,
    output logic hv_o
);
    // idle: serial clock stands low outside frames, master clear released
    initial begin
        sclk_o    = 1'b0;
        sdat_o    = 1'b0;
        sdat_oe_o = 1'b1;
        mc_n_o    = 1'b1;
        hv_o      = 1'b0;
    end
    // clock and data go low well before the high voltage rises
    task automatic hv_enter();
        sclk_o = 1'b0;
        sdat_o = 1'b0;
        // whole clock periods keep the pin edge off the device's sampling edge
        #96 hv_o = 1'b1;
    endtask
    task automatic hv_leave();
        hv_o = 1'b0;
    endtask
    // let go of the data pin so the device can answer on it
    task automatic release_data();
        sdat_oe_o = 1'b0;
    endtask
    // master clear low first, then 32 bits msb first, 125 ns per bit
    task automatic send_key(input logic [31:0] key);
        sdat_oe_o = 1'b1;
        mc_n_o    = 1'b0;
        #96;
        for (int i = 31; i >= 0; i--) begin
            sdat_o = key[i];
            #31 sclk_o = 1'b1;
            #62 sclk_o = 1'b0;
            #32;
        end
    endtask
    // ending the key attempt, session or not, is the only reason master clear goes high again
    task automatic mc_release();
        mc_n_o = 1'b1;
    endtask
endmodule

/* verification/spe_entry_tb.sv */
// bench for the entry block: high-voltage and low-voltage sessions
// assumes spe_defs.svh on the include path and the programmer model beside
`timescale 1ns/1ps
`include "spe_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %b got %b", nm, e, g); end end
module spe_entry_tb;
    import spe_pkg::*;
    logic      clk, resetn, cmd_d, cmd_oe, lv_en, clr_req;
    wire logic sclk, mc_n, hv, dut_d, dut_oe, pm_d, pm_oe;
    wire logic hv_sess, rst_en, wr_en, grant, pm;
    int        errors = 0;
    int        n_checks = 0;
    // released pin shows the inverse of the last value, never a stale copy
    wire logic pin = dut_oe ? dut_d : (pm_oe ? pm_d : ~pm_d);
    spe_entry i_spe_entry (.clk_i(clk), .resetn_i(resetn), .prog_serial_clock_i(sclk),
        .prog_serial_data_i(pin), .master_clear_n_i(mc_n), .hv_detect_i(hv),
        .cmd_data_out_i(cmd_d), .cmd_data_oe_i(cmd_oe), .prog_serial_data_o(dut_d),
        .prog_serial_data_oe_o(dut_oe), .low_voltage_entry_enable_i(lv_en),
        .en_clear_req_i(clr_req), .prog_mode_o(pm), .hv_session_o(hv_sess),
        .reset_fn_en_o(rst_en), .nvm_write_en_o(wr_en), .en_clear_grant_o(grant));
    spe_prog_model i_spe_prog_model (.sclk_o(sclk), .sdat_o(pm_d), .sdat_oe_o(pm_oe),
        .mc_n_o(mc_n), .hv_o(hv));
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait on program mode; the compare afterwards judges it
    task automatic wait_pm(input logic e);
        for (int k = 0; k < 20 && pm !== e; k++) @(negedge clk);
    endtask
    // high-voltage session: writes, pin drive and enable-bit clearing allowed
    task automatic t_hv();
        i_spe_prog_model.hv_enter();
        wait_pm(1'b1);
        `CHK("prog_mode", 1'b1, pm)
        `CHK("hv_session", 1'b1, hv_sess)
        `CHK("nvm_write", 1'b1, wr_en)
        // programmer lets go; a released pin reads 1 here, so only the device makes it 0
        i_spe_prog_model.release_data();
        cmd_oe  = 1'b1;
        cmd_d   = 1'b0;
        clr_req = 1'b1;
        cyc(2);
        `CHK("data_oe", 1'b1, dut_oe)
        `CHK("data_pin", 1'b0, pin)
        `CHK("clear_grant", 1'b1, grant)
        i_spe_prog_model.hv_leave();
        wait_pm(1'b0);
        `CHK("prog_mode", 1'b0, pm)
        cyc(2);
        `CHK("data_oe", 1'b0, dut_oe)
        `CHK("nvm_write", 1'b0, wr_en)
        `CHK("hv_session", 1'b0, hv_sess)
        `CHK("clear_grant", 1'b0, grant)
        clr_req = 1'b0;
        cmd_oe  = 1'b0;
    endtask
    // reset in mid-session drops it; without a new key no session comes back
    task automatic t_reset();
        i_spe_prog_model.send_key(`SPE_KEY_VALUE);
        cyc(8);
        `CHK("prog_mode", 1'b1, pm)
        resetn = 1'b0;
        cyc(1);
        `CHK("prog_mode", 1'b0, pm)
        `CHK("reset_fn", 1'b1, rst_en)
        resetn = 1'b1;
        cyc(8);
        `CHK("prog_mode", 1'b0, pm)
        `CHK("reset_fn", 1'b1, rst_en)
        i_spe_prog_model.mc_release();
        cyc(6);
    endtask
    // low-voltage key attempt; clearing must be refused in any such session
    task automatic t_lv(input logic [31:0] key, input logic en, input logic exp);
        lv_en = en;
        cyc(4);
        `CHK("reset_fn", en, rst_en)
        i_spe_prog_model.send_key(key);
        cyc(8);
        `CHK("prog_mode", exp, pm)
        `CHK("hv_session", 1'b0, hv_sess)
        clr_req = 1'b1;
        cyc(2);
        `CHK("clear_grant", 1'b0, grant)
        `CHK("nvm_write", exp, wr_en)
        clr_req = 1'b0;
        i_spe_prog_model.mc_release();
        cyc(6);
        `CHK("prog_mode", 1'b0, pm)
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        resetn  = 1'b0;
        cmd_d   = 1'b0;
        cmd_oe  = 1'b0;
        lv_en   = 1'b1;
        clr_req = 1'b0;
        cyc(3);
        resetn = 1'b1;
        cyc(4);
        t_hv();
        t_lv(`SPE_KEY_VALUE, 1'b1, 1'b1);
        t_lv(`SPE_KEY_VALUE ^ 32'h00000001, 1'b1, 1'b0);
        t_reset();
        t_lv(`SPE_KEY_VALUE, 1'b0, 1'b0);
        end_sim();
    end
    // four key frames take about 16.4 us; allow a wide margin
    initial begin
        #60000;
        errors++;
        end_sim();
    end
endmodule
